// ===== design/isss_pkg.sv
// Purpose: Shared constants for the interrupt service, sense and status block
// Assumes: 32 lines, one register per aligned 32-bit word
// Notes:   Addresses are full byte addresses on the register port
package isss_pkg;

    localparam int unsigned LINES = 32;

    // Register byte addresses
    localparam logic [31:0] ADDR_NORMAL_IN_SERVICE   = 32'h1000_0288;
    localparam logic [31:0] ADDR_FAST_IN_SERVICE     = 32'h1000_028C;
    localparam logic [31:0] ADDR_NORMAL_SENSITIVITY  = 32'h1000_0290;
    localparam logic [31:0] ADDR_FAST_SENSITIVITY    = 32'h1000_0294;
    localparam logic [31:0] ADDR_SOFTWARE_INJECTION  = 32'h1000_0298;
    localparam logic [31:0] ADDR_NORMAL_PENDING      = 32'h1000_029C;
    localparam logic [31:0] ADDR_FAST_PENDING        = 32'h1000_02A0;
    localparam logic [31:0] ADDR_RAW_SOURCE_VIEW     = 32'h1000_02A4;
    localparam logic [31:0] ADDR_DELIVERY_MODE       = 32'h1000_02A8;
    localparam logic [31:0] ADDR_EVENT_STATUS        = 32'h1000_02AC;
    localparam logic [31:0] ADDR_EVENT_MASK          = 32'h1000_02B0;

    // Values after reset
    localparam logic [31:0] RST_IN_SERVICE   = 32'h0000_0000;
    localparam logic [31:0] RST_SENSITIVITY  = 32'h0000_0001;
    localparam logic [31:0] RST_INJECTION    = 32'h0000_0000;
    localparam logic [31:0] RST_PENDING      = 32'h0000_0000;
    localparam logic [31:0] RST_RAW_SOURCE   = 32'h0000_0000;
    localparam logic        RST_MODE         = 1'b0;
    localparam logic [1:0]  RST_EVENT        = 2'h0;
    localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

    // Field positions
    localparam int unsigned MODE_SEL_BIT     = 0;
    localparam int unsigned EVT_NORMAL_BIT   = 0;
    localparam int unsigned EVT_FAST_BIT     = 1;
    localparam int unsigned EVT_WIDTH        = 2;

    // Path indices
    localparam int unsigned PATH_NORMAL      = 0;
    localparam int unsigned PATH_FAST        = 1;
    localparam int unsigned PATHS            = 2;

    // Mode select encoding
    localparam logic MODE_COMPAT_VECTORED    = 1'b0;
    localparam logic MODE_EXTERNAL_CTRL      = 1'b1;

endpackage

// ===== design/isss_core.sv
// Purpose: Service tracking, sensitivity, status and mode select for a
//          32-line interrupt controller with a normal and a fast path
// Assumes: Source select and mask bits come from the rest of the
//          controller on sys_clk; peripheral sources are asynchronous
// Notes:   Register port reads answer one cycle after the read strobe
//
// What this block does
// - Each line keeps an in-service bit per path, read back directly.
// - Writing one to normal end-of-service clears that line's in-service bit, except a level line whose source is still asserted and unmasked.
// - Writing one to fast end-of-service clears that line's in-service bit, except a level line whose source is still asserted and unmasked.
// - Sensitivity bit zero detects rising edges, one treats source as level.
// - Sensitivity resets with line 0 level, all others rising edge.
// - A 32-bit software injection register exists, resetting to zero.
// - Injected bits force the line's request ahead of path selection.
// - Each path has a read-only pending status register, reset zero.
// - Status bits include the path mask, so masked lines stop reading pending one cycle after the mask drops.
// - Raw source view shows asserted sources, unaffected by mask or select.
// - Raw source view is taken before any masking.
// - Mode bit 0 picks compatibility/vectored or external controller mode.
// - Mode bits 31:1 reserved read zero; register resets to zero.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module isss_core (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic [31:0] regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [31:0] regRdData,
    input  wire logic [31:0] intSource,
    input  wire logic [31:0] sourceToNormalPathSelect,
    input  wire logic [31:0] normalPathLineBits,
    input  wire logic [31:0] fastPathEnableBits,
    output logic             normalRequest,
    output logic             fastRequest,
    output logic             processorDeliveryMode,
    output logic             blockIrq
);

    function automatic logic regHit(input logic [31:0] addr,
                                    input logic [31:0] target);
        regHit = (addr == target);
    endfunction

    // Picks the normal or the fast copy of a per-path value
    function automatic logic [31:0] pathPick(input int unsigned path,
                                             input logic [31:0] normalVal,
                                             input logic [31:0] fastVal);
        pathPick = (path == isss_pkg::PATH_NORMAL) ? normalVal : fastVal;
    endfunction

    // Source synchroniser: three stages, a change is taken only when the
    // second and third stages agree, which filters one-cycle glitches
    logic [31:0] srcStage1;
    logic [31:0] srcStage2;
    logic [31:0] srcStage3;
    logic [31:0] rawSource;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            srcStage1 <= isss_pkg::RST_RAW_SOURCE;
            srcStage2 <= isss_pkg::RST_RAW_SOURCE;
            srcStage3 <= isss_pkg::RST_RAW_SOURCE;
        end else if (clkEn) begin
            srcStage1 <= intSource;
            srcStage2 <= srcStage1;
            srcStage3 <= srcStage2;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rawSource <= isss_pkg::RST_RAW_SOURCE;
        end else if (clkEn) begin
            rawSource <= (srcStage2 & srcStage3)
                       | (rawSource & (srcStage2 ^ srcStage3));
        end
    end

    // Software injection: a debug aid, so it skips the synchroniser and
    // acts in the cycle after the write
    logic [31:0] softwareInjection;
    logic [31:0] effectiveSource;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            softwareInjection <= isss_pkg::RST_INJECTION;
        end else if (clkEn && regWrEn
                     && regHit(regAddr,
                               isss_pkg::ADDR_SOFTWARE_INJECTION)) begin
            softwareInjection <= regWrData;
        end
    end

    // Injection is merged before the path select so it can test either path
    assign effectiveSource = rawSource | softwareInjection;

    // Per-path state
    wire [31:0] pathSens      [isss_pkg::PATHS];
    wire [31:0] pathInService [isss_pkg::PATHS];
    wire [31:0] pathStatus    [isss_pkg::PATHS];
    wire        pathNewEvent  [isss_pkg::PATHS];

    genvar p;
    generate
        for (p = 0; p < isss_pkg::PATHS; p = p + 1) begin : gPath
            localparam logic [31:0] ADDR_EOI = (p == isss_pkg::PATH_NORMAL)
                ? isss_pkg::ADDR_NORMAL_IN_SERVICE
                : isss_pkg::ADDR_FAST_IN_SERVICE;
            localparam logic [31:0] ADDR_SENS = (p == isss_pkg::PATH_NORMAL)
                ? isss_pkg::ADDR_NORMAL_SENSITIVITY
                : isss_pkg::ADDR_FAST_SENSITIVITY;

            logic [31:0] sensitivity;
            logic [31:0] inService;
            logic [31:0] status;
            logic [31:0] edgeLatch;
            logic [31:0] prevRequest;
            logic [31:0] request;
            logic [31:0] pathMask;
            logic [31:0] eoiClear;
            logic [31:0] next_edgeLatch;
            logic [31:0] next_status;

            // Every source goes to exactly one of the two paths
            assign request = effectiveSource
                & pathPick(p, sourceToNormalPathSelect,
                           ~sourceToNormalPathSelect);
            assign pathMask = pathPick(p, normalPathLineBits,
                                       fastPathEnableBits);

            assign eoiClear = (clkEn && regWrEn && regHit(regAddr, ADDR_EOI))
                ? regWrData : isss_pkg::READ_ZERO;

            // A new edge in the clearing cycle survives: set wins. Level
            // lines hold no latch, so a later switch to edge mode cannot
            // raise a stale request
            assign next_edgeLatch = ((edgeLatch & ~eoiClear)
                                   | (request & ~prevRequest))
                                  & ~sensitivity;

            assign next_status = ((sensitivity & request)
                                | (~sensitivity & next_edgeLatch))
                               & pathMask;

            // Plain read-write bits, written whole, one bit per line
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sensitivity <= isss_pkg::RST_SENSITIVITY;
                end else if (clkEn && regWrEn
                             && regHit(regAddr, ADDR_SENS)) begin
                    sensitivity <= regWrData;
                end
            end

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    prevRequest <= isss_pkg::RST_PENDING;
                    edgeLatch   <= isss_pkg::RST_PENDING;
                end else if (clkEn) begin
                    prevRequest <= request;
                    edgeLatch   <= next_edgeLatch;
                end
            end

            // Registered, so status trails the request by one cycle
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    status <= isss_pkg::RST_PENDING;
                end else if (clkEn) begin
                    status <= next_status;
                end
            end

            // A level line still asserted and unmasked after end-of-service stays in
            // service; software must quiet or mask the source first
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    inService <= isss_pkg::RST_IN_SERVICE;
                end else if (clkEn) begin
                    inService <= (inService & ~eoiClear)
                               | next_status;
                end
            end

            assign pathSens[p]      = sensitivity;
            assign pathInService[p] = inService;
            assign pathStatus[p]    = status;
            assign pathNewEvent[p]  = |(next_status & ~status);
        end
    endgenerate

    // Processor request lines, registered so the pins cannot glitch
    // while several status bits change in one cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            normalRequest <= 1'b0;
            fastRequest   <= 1'b0;
        end else if (clkEn) begin
            normalRequest <= |pathStatus[isss_pkg::PATH_NORMAL];
            fastRequest   <= |pathStatus[isss_pkg::PATH_FAST];
        end
    end

    // Delivery mode select
    // Only bit 0 is stored; the reserved bits cannot be set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            processorDeliveryMode <= isss_pkg::RST_MODE;
        end else if (clkEn && regWrEn
                     && regHit(regAddr, isss_pkg::ADDR_DELIVERY_MODE)) begin
            processorDeliveryMode <= regWrData[isss_pkg::MODE_SEL_BIT];
        end
    end

    // Block interrupt: sticky new-pending events, cleared by reading
    logic [isss_pkg::EVT_WIDTH-1:0] eventStatus;
    logic [isss_pkg::EVT_WIDTH-1:0] eventMask;
    logic [isss_pkg::EVT_WIDTH-1:0] eventSet;
    logic                           eventRead;

    assign eventSet[isss_pkg::EVT_NORMAL_BIT] =
        pathNewEvent[isss_pkg::PATH_NORMAL];
    assign eventSet[isss_pkg::EVT_FAST_BIT] =
        pathNewEvent[isss_pkg::PATH_FAST];
    // A read while frozen does not clear, as the flop below is gated
    assign eventRead = regRdEn
                     && regHit(regAddr, isss_pkg::ADDR_EVENT_STATUS);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            eventStatus <= isss_pkg::RST_EVENT;
        end else if (clkEn) begin
            // An event landing in the read cycle is kept for the next read
            eventStatus <= (eventRead ? isss_pkg::RST_EVENT : eventStatus)
                         | eventSet;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            eventMask <= isss_pkg::RST_EVENT;
        end else if (clkEn && regWrEn
                     && regHit(regAddr, isss_pkg::ADDR_EVENT_MASK)) begin
            eventMask <= regWrData[isss_pkg::EVT_WIDTH-1:0];
        end
    end

    // Level output: high until the status is read or the mask drops
    assign blockIrq = |(eventStatus & eventMask);

    // Read path: reserved mode bits and unmapped words read as zero
    // Strobe-gated so the read data is zero outside its one cycle
    logic [31:0] next_rdData;

    always_comb begin
        next_rdData = isss_pkg::READ_ZERO;
        if (regRdEn) begin
            unique case (regAddr)
                isss_pkg::ADDR_NORMAL_IN_SERVICE:
                    next_rdData = pathInService[isss_pkg::PATH_NORMAL];
                isss_pkg::ADDR_FAST_IN_SERVICE:
                    next_rdData = pathInService[isss_pkg::PATH_FAST];
                isss_pkg::ADDR_NORMAL_SENSITIVITY:
                    next_rdData = pathSens[isss_pkg::PATH_NORMAL];
                isss_pkg::ADDR_FAST_SENSITIVITY:
                    next_rdData = pathSens[isss_pkg::PATH_FAST];
                isss_pkg::ADDR_SOFTWARE_INJECTION:
                    next_rdData = softwareInjection;
                isss_pkg::ADDR_NORMAL_PENDING:
                    next_rdData = pathStatus[isss_pkg::PATH_NORMAL];
                isss_pkg::ADDR_FAST_PENDING:
                    next_rdData = pathStatus[isss_pkg::PATH_FAST];
                isss_pkg::ADDR_RAW_SOURCE_VIEW:
                    next_rdData = rawSource;
                isss_pkg::ADDR_DELIVERY_MODE:
                    next_rdData = {31'h0000_0000,
                                   processorDeliveryMode};
                isss_pkg::ADDR_EVENT_STATUS:
                    next_rdData = {30'h0000_0000, eventStatus};
                isss_pkg::ADDR_EVENT_MASK:
                    next_rdData = {30'h0000_0000, eventMask};
                default:
                    next_rdData = isss_pkg::READ_ZERO;
            endcase
        end
    end

    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= isss_pkg::READ_ZERO;
        end else if (clkEn) begin
            regRdData <= next_rdData;
        end
    end

endmodule // isss_core

`default_nettype wire

// ===== verif/isss_monitor.sv
// Purpose: Assertions on the register port and request outputs of isss_core
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Mask checks skip reads in the cycle right after a mask change
`timescale 1ns/1ps
`default_nettype none

module isss_monitor (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        clkEn,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [31:0] regRdData,
    input wire logic [31:0] normalPathLineBits,
    input wire logic [31:0] fastPathEnableBits,
    input wire logic        normalRequest,
    input wire logic        fastRequest,
    input wire logic        processorDeliveryMode
);
    default clocking monCb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic wrMode;
    logic wrSens;
    logic rdSens;
    assign wrMode = clkEn && regWrEn
        && regAddr == isss_pkg::ADDR_DELIVERY_MODE;
    assign wrSens = clkEn && regWrEn
        && regAddr == isss_pkg::ADDR_NORMAL_SENSITIVITY;
    assign rdSens = clkEn && regRdEn
        && regAddr == isss_pkg::ADDR_NORMAL_SENSITIVITY;

    mode_write_a:
        assert property (wrMode |=> {31'h0, processorDeliveryMode}
            == ($past(regWrData) & 32'h0000_0001))
        else $error("mode bit missed a write");
    mode_hold_a:
        assert property (clkEn && !wrMode |=> $stable(processorDeliveryMode))
        else $error("mode bit moved without a write");
    mode_read_a:
        assert property (clkEn && regRdEn
            && regAddr == isss_pkg::ADDR_DELIVERY_MODE
            |=> regRdData == {31'h0, processorDeliveryMode})
        else $error("mode read is not the zero-extended mode bit");
    normal_mask_a:
        assert property (clkEn && regRdEn && $stable(normalPathLineBits)
            && regAddr == isss_pkg::ADDR_NORMAL_PENDING
            |=> (regRdData & ~$past(normalPathLineBits)) == 32'h0)
        else $error("masked line read as normal pending");
    fast_mask_a:
        assert property (clkEn && regRdEn && $stable(fastPathEnableBits)
            && regAddr == isss_pkg::ADDR_FAST_PENDING
            |=> (regRdData & ~$past(fastPathEnableBits)) == 32'h0)
        else $error("masked line read as fast pending");
    normal_quiet_a:
        assert property ((normalPathLineBits == 32'h0) [*3] |-> !normalRequest)
        else $error("normal request with every line masked");
    fast_quiet_a:
        assert property ((fastPathEnableBits == 32'h0) [*3] |-> !fastRequest)
        else $error("fast request with every line masked");
    sense_readback_a:
        assert property (wrSens ##1 !regWrEn ##1 rdSens
            |=> regRdData == $past(regWrData, 3))
        else $error("sensitivity read differs from last write");
endmodule // isss_monitor

bind isss_core isss_monitor i_mon (.sys_clk, .rst_n, .clkEn, .regAddr,
    .regWrData, .regWrEn, .regRdEn, .regRdData, .normalPathLineBits,
    .fastPathEnableBits, .normalRequest, .fastRequest, .processorDeliveryMode);
`default_nettype wire

// ===== verif/isss_partner.sv
// Purpose: Far side: peripheral source levels and the processor's inputs
// Assumes: Sources are asynchronous levels that the core synchronises
// Notes:   Sources change only when the bench asks
`timescale 1ns/1ps
`default_nettype none

module isss_partner (
    input  wire logic        sys_clk,
    input  wire logic        normalRequest,
    input  wire logic        fastRequest,
    output var  logic [31:0] intSource,
    output var  logic [1:0]  seenRequest
);
    initial intSource = 32'h0000_0000;

    task automatic drive(input logic [31:0] lines);
        @(posedge sys_clk);
        intSource <= lines;
    endtask

    // Processor latches both request pins every cycle
    always_ff @(posedge sys_clk) begin
        seenRequest <= {fastRequest, normalRequest};
    end
endmodule // isss_partner
`default_nettype wire

// ===== verif/test_interrupt_service_sense_status.sv
// Purpose: Register-level test of isss_core against a far-side model
// Assumes: clkEn high except in one frozen-write check; path select and masks driven by the bench
// Notes:   Ten-cycle waits cover the three-stage source synchroniser
`timescale 1ns/1ps
`default_nettype none

module test_interrupt_service_sense_status;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clkEn = 1'b1;
    logic [31:0] regAddr = 32'h0000_0000;
    logic [31:0] regWrData = 32'h0000_0000;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [31:0] regRdData;
    logic [31:0] intSource;
    logic [31:0] sourceToNormalPathSelect = 32'hFFFF_FFDF;
    logic [31:0] normalPathLineBits = 32'h0000_0000;
    logic [31:0] fastPathEnableBits = 32'h0000_0000;
    logic        normalRequest;
    logic        fastRequest;
    logic        processorDeliveryMode;
    logic        blockIrq;
    logic [1:0]  seenRequest;
    int          error_cnt = 0;
    int          total_checks = 0;
    localparam logic [31:0] RW_ADDR [8] = '{isss_pkg::ADDR_NORMAL_SENSITIVITY,
        isss_pkg::ADDR_FAST_SENSITIVITY, isss_pkg::ADDR_SOFTWARE_INJECTION,
        isss_pkg::ADDR_DELIVERY_MODE, isss_pkg::ADDR_NORMAL_PENDING,
        isss_pkg::ADDR_RAW_SOURCE_VIEW, isss_pkg::ADDR_EVENT_MASK,
        32'h1000_02B4};
    localparam logic [31:0] RW_EXP [8] = '{32'hA5A5_5A5B, 32'hA5A5_5A5B,
        32'hA5A5_5A5B, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0003, 32'h0000_0000};

    always #2 sys_clk = ~sys_clk;

    isss_core i_dut (.sys_clk, .rst_n, .clkEn, .regAddr, .regWrData, .regWrEn,
        .regRdEn, .regRdData, .intSource, .sourceToNormalPathSelect,
        .normalPathLineBits, .fastPathEnableBits, .normalRequest, .fastRequest,
        .processorDeliveryMode, .blockIrq);
    isss_partner i_peer (.sys_clk, .normalRequest, .fastRequest, .intSource,
        .seenRequest);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        regWrEn <= 1'b1;
        regAddr <= addr;
        regWrData <= data;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        @(posedge sys_clk);
        regRdEn <= 1'b1;
        regAddr <= addr;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        @(negedge sys_clk);
        chk(regRdData, exp);
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask

    // Walks the contiguous map from in-service up to the event mask
    task automatic check_resets();
        for (int i = 0; i < 11; i++) begin
            rd(isss_pkg::ADDR_NORMAL_IN_SERVICE + 32'(4 * i),
            (i == 2 || i == 3) ? 32'h0000_0001 : 32'h0000_0000);
        end
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        do_reset();
        check_resets();
        for (int i = 0; i < 8; i++) begin
            wr(RW_ADDR[i], 32'hA5A5_5A5B);
            rd(RW_ADDR[i], RW_EXP[i]);
        end
        chk({31'h0, processorDeliveryMode}, 32'h0000_0001);
        do_reset();
        check_resets();
        chk({31'h0, processorDeliveryMode}, 32'h0000_0000);
        // A write while the clock enable is low must not land
        @(posedge sys_clk);
        clkEn <= 1'b0;
        wr(isss_pkg::ADDR_SOFTWARE_INJECTION, 32'h0000_0004);
        clkEn <= 1'b1;
        rd(isss_pkg::ADDR_SOFTWARE_INJECTION, 32'h0000_0000);
        // Edge line 3 on the normal path, raised by injection
        @(posedge sys_clk);
        normalPathLineBits <= 32'h0000_0008;
        fastPathEnableBits <= 32'h0000_0020;
        wr(isss_pkg::ADDR_EVENT_MASK, 32'h0000_0001);
        wr(isss_pkg::ADDR_SOFTWARE_INJECTION, 32'h0000_0008);
        repeat (2) @(posedge sys_clk);
        rd(isss_pkg::ADDR_NORMAL_PENDING, 32'h0000_0008);
        rd(isss_pkg::ADDR_NORMAL_IN_SERVICE, 32'h0000_0008);
        chk({31'h0, seenRequest[0]}, 32'h0000_0001);
        chk({31'h0, blockIrq}, 32'h0000_0001);
        rd(isss_pkg::ADDR_EVENT_STATUS, 32'h0000_0001);
        chk({31'h0, blockIrq}, 32'h0000_0000);
        wr(isss_pkg::ADDR_NORMAL_IN_SERVICE, 32'h0000_0000);
        rd(isss_pkg::ADDR_NORMAL_IN_SERVICE, 32'h0000_0008);
        wr(isss_pkg::ADDR_NORMAL_IN_SERVICE, 32'h0000_0008);
        rd(isss_pkg::ADDR_NORMAL_PENDING, 32'h0000_0000);
        rd(isss_pkg::ADDR_NORMAL_IN_SERVICE, 32'h0000_0000);
        wr(isss_pkg::ADDR_SOFTWARE_INJECTION, 32'h0000_0000);
        // Level line 5 on the fast path from a hardware source
        wr(isss_pkg::ADDR_FAST_SENSITIVITY, 32'h0000_0021);
        i_peer.drive(32'h0000_0020);
        repeat (10) @(posedge sys_clk);
        rd(isss_pkg::ADDR_RAW_SOURCE_VIEW, 32'h0000_0020);
        rd(isss_pkg::ADDR_FAST_PENDING, 32'h0000_0020);
        chk({31'h0, seenRequest[1]}, 32'h0000_0001);
        chk({31'h0, blockIrq}, 32'h0000_0000);
        rd(isss_pkg::ADDR_EVENT_STATUS, 32'h0000_0002);
        wr(isss_pkg::ADDR_FAST_IN_SERVICE, 32'h0000_0020);
        rd(isss_pkg::ADDR_FAST_IN_SERVICE, 32'h0000_0020);
        @(posedge sys_clk);
        fastPathEnableBits <= 32'h0000_0000;
        repeat (3) @(posedge sys_clk);
        rd(isss_pkg::ADDR_FAST_PENDING, 32'h0000_0000);
        rd(isss_pkg::ADDR_RAW_SOURCE_VIEW, 32'h0000_0020);
        i_peer.drive(32'h0000_0000);
        repeat (10) @(posedge sys_clk);
        wr(isss_pkg::ADDR_FAST_IN_SERVICE, 32'h0000_0020);
        rd(isss_pkg::ADDR_FAST_IN_SERVICE, 32'h0000_0000);
        report_and_stop();
    end
endmodule // test_interrupt_service_sense_status
`default_nettype wire
